/* logic/gpr_file.sv */
// windowed general-purpose register file with register-number translation
//
// What this block does
// - 64 global and 128 local entries, split by msb
// - two source numbers, one result number, eight bits
// - msb clear: global, number used unchanged
// - msb set: low seven plus sp[8:2], msb kept
// - number zero takes that field's indirect pointer
// - global register one holds the stack pointer
// - globals two to sixty-three have no storage
// - stack pointer is a full 32-bit operand
// - hidden shadow updates only on arithmetic/logic writes
// - sp change reaches translation after pipeline delay
// - double operands occupy a register pair
// - direct or via one of three pointers
// - pointer numbers skip stack pointer addition
// - move-to-special loads pointer from bits 9:2
`timescale 1ns/1ps
module gpr_file (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire gpr_pkg::rd_req_t rd_req,
	input wire gpr_pkg::wr_req_t wr_req,
	input wire gpr_pkg::ptr_req_t ptr_req,
	output logic rd_valid_r,
	output logic [31:0] rd_a_data_r,
	output logic [31:0] rd_b_data_r,
	output logic [7:0] rd_a_abs_r,
	output logic [7:0] rd_b_abs_r,
	output logic wr_busy_r,
	output gpr_pkg::ptrs_t ptrs_r
);
	import gpr_pkg::*;

	// ************************************************************
	// decode helpers
	// ************************************************************

	// register number to absolute number; zero picks the pointer
	function automatic logic [NUM_W-1:0] xlate(
		input logic [NUM_W-1:0] num,
		input logic [NUM_W-1:0] ptr,
		input logic [IDX_W-1:0] base
	);
		logic [IDX_W-1:0] sum;
		sum = num[IDX_W-1:0] + base;
		if (num == INDIRECT_NUM) begin
			return ptr;
		end else if (num[NUM_W-1]) begin
			return {1'b1, sum};
		end else begin
			return num;
		end
	endfunction : xlate

	// second location of a pair, staying inside its own region
	function automatic logic [NUM_W-1:0] pair_next(input logic [NUM_W-1:0] abs_num);
		logic [IDX_W-1:0] low;
		low = abs_num[IDX_W-1:0] + 7'h01;
		return {abs_num[NUM_W-1], low};
	endfunction : pair_next

	// absolute number to storage index
	function automatic logic [NUM_W-1:0] store_idx(input logic [NUM_W-1:0] abs_num);
		return abs_num - FIRST_STORED_NUM;
	endfunction : store_idx

	// ************************************************************
	// state
	// ************************************************************
	logic [WORD_W-1:0] sp_r; // architectural global register one
	logic [WORD_W-1:0] shadow_r; // hidden copy for local translation
	logic [WORD_W-1:0] sp_dly_r [SP_DELAY_STAGES];
	logic pend_r;
	logic [NUM_W-1:0] pend_abs_r;
	logic [WORD_W-1:0] pend_data_r;
	logic rd_stage_r;
	logic [NUM_W-1:0] abs_a_r;
	logic [NUM_W-1:0] abs_b_r;
	logic [WORD_W-1:0] q_a;
	logic [WORD_W-1:0] q_b;

	// ************************************************************
	// translation
	// ************************************************************

	// local base comes from the delayed shadow, never from sp_r
	wire [IDX_W-1:0] base = sp_dly_r[SP_DELAY_STAGES-1][SP_BASE_MSB:SP_BASE_LSB];
	wire [NUM_W-1:0] abs_a = xlate(rd_req.a_num, ptrs_r.operand_a_pointer, base);
	wire [NUM_W-1:0] abs_a_raw = xlate(rd_req.b_num, ptrs_r.operand_b_pointer, base);
	wire [NUM_W-1:0] abs_c = xlate(rd_req.c_num, ptrs_r.result_pointer, base);
	// a double read fetches the pair on port b
	wire [NUM_W-1:0] abs_b = rd_req.dp ? pair_next(abs_a) : abs_a_raw;
	wire [NUM_W-1:0] wr_abs = xlate(wr_req.num, ptrs_r.result_pointer, base);

	// ************************************************************
	// write selection
	// ************************************************************

	// the pending high word of a double owns the single write port
	wire new_wr = wr_req.en && !pend_r;
	wire [NUM_W-1:0] wsel_abs = pend_r ? pend_abs_r : wr_abs;
	wire [WORD_W-1:0] wsel_data = pend_r ? pend_data_r : wr_req.data;
	wire wsel_en = pend_r || new_wr;
	// numbers below 64 other than one have nowhere to go
	wire wsel_stored = wsel_abs >= FIRST_STORED_NUM;
	wire wsel_sp = wsel_en && (wsel_abs == STACK_PTR_NUM);
	// only an arithmetic/logic result refreshes the shadow
	wire shadow_load = wsel_sp && !pend_r && wr_req.alu_class;

	// ************************************************************
	// storage
	// ************************************************************
	gpr_store u_store (
		.clk(clk),
		.ce(ce),
		.rd_a_idx(store_idx(abs_a)),
		.rd_b_idx(store_idx(abs_b)),
		.wr_en(wsel_en && wsel_stored),
		.wr_idx(store_idx(wsel_abs)),
		.wr_data(wsel_data),
		.rd_a_q(q_a),
		.rd_b_q(q_b)
	);

	// ************************************************************
	// read data selection
	// ************************************************************

	// register one reads the live stack pointer, unstored numbers read zero
	wire [WORD_W-1:0] word_a = (abs_a_r == STACK_PTR_NUM) ? sp_r :
		(abs_a_r >= FIRST_STORED_NUM) ? q_a : WORD_RESET;
	wire [WORD_W-1:0] word_b = (abs_b_r == STACK_PTR_NUM) ? sp_r :
		(abs_b_r >= FIRST_STORED_NUM) ? q_b : WORD_RESET;

	// ************************************************************
	// stack pointer and its shadow
	// ************************************************************

	// any class may write the stack pointer as an ordinary operand
	always_ff @(posedge clk) begin
		if (rst) begin
			sp_r <= WORD_RESET;
		end else if (ce && wsel_sp) begin
			sp_r <= wsel_data;
		end
	end

	// other-class writes leave a stale shadow; software must rewrite sp
	always_ff @(posedge clk) begin
		if (rst) begin
			shadow_r <= WORD_RESET;
		end else if (ce && shadow_load) begin
			shadow_r <= wr_req.data;
		end
	end

	// delay line between the shadow and the translator
	genvar gi;
	generate
		for (gi = 0; gi < SP_DELAY_STAGES; gi++) begin : g_sp_dly
			always_ff @(posedge clk) begin
				if (rst) begin
					sp_dly_r[gi] <= WORD_RESET;
				end else if (ce) begin
					sp_dly_r[gi] <= (gi == 0) ? shadow_r : sp_dly_r[(gi == 0) ? 0 : gi - 1];
				end
			end
		end
	endgenerate

	// ************************************************************
	// double-precision write sequencing
	// ************************************************************

	// the high word is written one cycle after the low word
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_r <= 1'b0;
			pend_abs_r <= PTR_RESET;
			pend_data_r <= WORD_RESET;
			wr_busy_r <= 1'b0;
		end else if (ce) begin
			pend_r <= new_wr && wr_req.dp;
			pend_abs_r <= pair_next(wr_abs);
			pend_data_r <= wr_req.data_hi;
			wr_busy_r <= new_wr && wr_req.dp;
		end
	end

	// ************************************************************
	// indirect pointers
	// ************************************************************

	// a move-to-special load beats a simultaneous set of all three
	always_ff @(posedge clk) begin
		if (rst) begin
			ptrs_r <= '{PTR_RESET, PTR_RESET, PTR_RESET};
		end else if (ce && ptr_req.mtsr_en) begin
			unique case (ptr_req.sel)
				SEL_RESULT: begin
					ptrs_r.result_pointer <= ptr_req.src[PTR_FIELD_MSB:PTR_FIELD_LSB];
				end
				SEL_OPERAND_A: begin
					ptrs_r.operand_a_pointer <= ptr_req.src[PTR_FIELD_MSB:PTR_FIELD_LSB];
				end
				SEL_OPERAND_B: begin
					ptrs_r.operand_b_pointer <= ptr_req.src[PTR_FIELD_MSB:PTR_FIELD_LSB];
				end
				default: begin
					ptrs_r <= ptrs_r; // code 3 selects no pointer
				end
			endcase
		end else if (ce && ptr_req.setip_en) begin
			// set-all stores translated numbers, local addition already applied
			ptrs_r <= '{abs_a, abs_a_raw, abs_c};
		end
	end

	// ************************************************************
	// read pipeline
	// ************************************************************

	// first edge latches translated numbers while the array reads
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_stage_r <= 1'b0;
			abs_a_r <= PTR_RESET;
			abs_b_r <= PTR_RESET;
		end else if (ce) begin
			rd_stage_r <= rd_req.en;
			abs_a_r <= abs_a;
			abs_b_r <= abs_b;
		end
	end

	// second edge presents the words from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_valid_r <= 1'b0;
			rd_a_data_r <= WORD_RESET;
			rd_b_data_r <= WORD_RESET;
			rd_a_abs_r <= PTR_RESET;
			rd_b_abs_r <= PTR_RESET;
		end else if (ce) begin
			rd_valid_r <= rd_stage_r;
			rd_a_data_r <= word_a;
			rd_b_data_r <= word_b;
			rd_a_abs_r <= abs_a_r;
			rd_b_abs_r <= abs_b_r;
		end
	end
endmodule : gpr_file

/* logic/gpr_pkg.sv */
// shared types and constants for the windowed general-purpose register file
package gpr_pkg;
	// ************************************************************
	// numbers and geometry
	// ************************************************************
	localparam int WORD_W = 32;
	localparam int NUM_W = 8;
	localparam int IDX_W = 7;
	localparam int GLOBAL_COUNT = 64;
	localparam int LOCAL_COUNT = 128;
	localparam int STORE_DEPTH = GLOBAL_COUNT + LOCAL_COUNT;
	localparam logic [NUM_W-1:0] INDIRECT_NUM = 8'h00;
	localparam logic [NUM_W-1:0] STACK_PTR_NUM = 8'h01;
	localparam logic [NUM_W-1:0] FIRST_STORED_NUM = 8'h40;
	// stack pointer bits that form the local base
	localparam int SP_BASE_LSB = 2;
	localparam int SP_BASE_MSB = 8;
	// pointer field inside a move-to-special-register operand
	localparam int PTR_FIELD_LSB = 2;
	localparam int PTR_FIELD_MSB = 9;
	// extra cycles before a new stack pointer reaches local translation
	localparam int SP_DELAY_STAGES = 2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
	localparam logic [NUM_W-1:0] PTR_RESET = 8'h00;

	// pointer selection for a move-to-special-register load
	typedef enum logic [1:0] {
		SEL_RESULT = 2'h0,
		SEL_OPERAND_A = 2'h1,
		SEL_OPERAND_B = 2'h2
	} ptr_sel_t;

	// read request: two operand numbers plus the result number
	typedef struct packed {
		logic en;
		logic dp;
		logic [NUM_W-1:0] a_num;
		logic [NUM_W-1:0] b_num;
		logic [NUM_W-1:0] c_num;
	} rd_req_t;

	// result write
	typedef struct packed {
		logic en;
		logic dp;
		logic alu_class;
		logic [NUM_W-1:0] num;
		logic [WORD_W-1:0] data;
		logic [WORD_W-1:0] data_hi;
	} wr_req_t;

	// indirect pointer loads
	typedef struct packed {
		logic mtsr_en;
		ptr_sel_t sel;
		logic [WORD_W-1:0] src;
		logic setip_en;
	} ptr_req_t;

	// current indirect pointers
	typedef struct packed {
		logic [NUM_W-1:0] operand_a_pointer;
		logic [NUM_W-1:0] operand_b_pointer;
		logic [NUM_W-1:0] result_pointer;
	} ptrs_t;
endpackage : gpr_pkg

/* logic/gpr_store.sv */
// storage array: two registered read ports and one write port
`timescale 1ns/1ps
module gpr_store (
	input wire logic clk,
	input wire logic ce,
	input wire logic [7:0] rd_a_idx,
	input wire logic [7:0] rd_b_idx,
	input wire logic wr_en,
	input wire logic [7:0] wr_idx,
	input wire logic [31:0] wr_data,
	output logic [31:0] rd_a_q,
	output logic [31:0] rd_b_q
);
	import gpr_pkg::*;

	logic [WORD_W-1:0] mem [STORE_DEPTH];

	// write port; no reset, contents are undefined until written
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	// registered reads return the old word on a same-cycle write
	always_ff @(posedge clk) begin
		if (ce) begin
			rd_a_q <= mem[rd_a_idx];
			rd_b_q <= mem[rd_b_idx];
		end
	end
endmodule : gpr_store

/* verif/pipe_model.sv */
// pipeline-side model that issues register file requests
`timescale 1ns/1ps
module pipe_model (
	input wire logic clk,
	output gpr_pkg::rd_req_t rd_req,
	output gpr_pkg::wr_req_t wr_req,
	output gpr_pkg::ptr_req_t ptr_req
);
	import gpr_pkg::*;
	// ****
	// request tasks
	// ****
	initial begin
		rd_req = '0;
		wr_req = '0;
		ptr_req = '0;
	end
	// fields flip on release so a stale number never looks like a live one
	task automatic wr(input logic [7:0] n, input logic [31:0] d, input logic [31:0] dh,
		input logic dp, input logic alu);
		@(posedge clk);
		wr_req <= '{1'b1, dp, alu, n, d, dh};
		@(posedge clk);
		wr_req <= '{1'b0, ~dp, ~alu, ~n, ~d, ~dh};
	endtask : wr
	// answer lands one edge after the taking edge
	task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic dp);
		@(posedge clk);
		rd_req <= '{1'b1, dp, a, b, 8'h00};
		@(posedge clk);
		rd_req <= '{1'b0, ~dp, ~a, ~b, 8'hff};
		@(posedge clk);
		#1;
	endtask : rd
	task automatic mtsr(input ptr_sel_t s, input logic [31:0] src);
		@(posedge clk);
		ptr_req <= '{1'b1, s, src, 1'b0};
		@(posedge clk);
		ptr_req <= '{1'b0, s, ~src, 1'b0};
	endtask : mtsr
	// set-all takes its three numbers from the read request fields
	task automatic setip(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(posedge clk);
		rd_req <= '{1'b0, 1'b0, a, b, c};
		ptr_req <= '{1'b0, SEL_RESULT, 32'h0, 1'b1};
		@(posedge clk);
		rd_req <= '{1'b0, 1'b0, ~a, ~b, ~c};
		ptr_req <= '{1'b0, SEL_RESULT, 32'h0, 1'b0};
	endtask : setip
endmodule : pipe_model

/* verif/gpr_file_asserts.sv */
// port-level checks for the register file
`timescale 1ns/1ps
module gpr_file_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire gpr_pkg::rd_req_t rd_req,
	input wire gpr_pkg::wr_req_t wr_req,
	input wire gpr_pkg::ptr_req_t ptr_req,
	input wire logic rd_valid_r,
	input wire logic [31:0] rd_a_data_r,
	input wire logic [31:0] rd_b_data_r,
	input wire logic [7:0] rd_a_abs_r,
	input wire logic [7:0] rd_b_abs_r,
	input wire logic wr_busy_r,
	input wire gpr_pkg::ptrs_t ptrs_r
);
	import gpr_pkg::*;
	// ****
	// read timing and translation
	// ****
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	read_answer_a: assert property (ce && rd_req.en ##1 ce |=> rd_valid_r)
		else $error("read not answered");
	read_quiet_a: assert property (ce && !rd_req.en ##1 ce |=> !rd_valid_r)
		else $error("valid without read");
	global_abs_a: assert property (ce && rd_req.en && !rd_req.a_num[7] && rd_req.a_num != 8'h00
		##1 ce |=> rd_a_abs_r == $past(rd_req.a_num, 2)) else $error("global number changed");
	indirect_abs_a: assert property (ce && rd_req.en && rd_req.a_num == 8'h00 ##1 ce
		|=> rd_a_abs_r == $past(ptrs_r.operand_a_pointer, 2)) else $error("pointer unused");
	local_msb_a: assert property (ce && rd_req.en && rd_req.b_num[7] && !rd_req.dp ##1 ce
		|=> rd_b_abs_r[7]) else $error("local msb lost");
	pair_abs_a: assert property (ce && rd_req.en && rd_req.dp ##1 ce
		|=> rd_b_abs_r == {rd_a_abs_r[7], rd_a_abs_r[6:0] + 7'h01}) else $error("bad pair");
	unstored_read_a: assert property (ce && rd_req.en && rd_req.a_num inside {[8'h02:8'h3f]} ##1 ce
		|=> rd_a_data_r == 32'h0) else $error("unstored read nonzero");
	// ****
	// writes and pointers
	// ****
	dbl_busy_a: assert property (ce && wr_req.en && wr_req.dp && !wr_busy_r
		|=> wr_busy_r ##1 (!$past(ce) || !wr_busy_r)) else $error("double write busy wrong");
	ptr_a_load_a: assert property (ce && ptr_req.mtsr_en && ptr_req.sel == SEL_OPERAND_A
		|=> ptrs_r.operand_a_pointer == $past(ptr_req.src[9:2])) else $error("ptr a");
	ptr_c_load_a: assert property (ce && ptr_req.mtsr_en && ptr_req.sel == SEL_RESULT
		|=> ptrs_r.result_pointer == $past(ptr_req.src[9:2])) else $error("ptr c");
endmodule : gpr_file_asserts
bind gpr_file gpr_file_asserts chk (.clk(clk), .rst(rst), .ce(ce), .rd_req(rd_req),
	.wr_req(wr_req), .ptr_req(ptr_req), .rd_valid_r(rd_valid_r), .rd_a_data_r(rd_a_data_r),
	.rd_b_data_r(rd_b_data_r), .rd_a_abs_r(rd_a_abs_r), .rd_b_abs_r(rd_b_abs_r),
	.wr_busy_r(wr_busy_r), .ptrs_r(ptrs_r));

/* verif/windowed_gpr_file_addressing_tb.sv */
// self-checking bench for the windowed register file
`timescale 1ns/1ps
module windowed_gpr_file_addressing_tb;
	import gpr_pkg::*;
	// ****
	// clock, reset, design and pipeline model
	// ****
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	rd_req_t rd_req;
	wr_req_t wr_req;
	ptr_req_t ptr_req;
	logic rd_valid_r;
	logic wr_busy_r;
	logic [31:0] a_d;
	logic [31:0] b_d;
	logic [7:0] a_abs;
	logic [7:0] b_abs;
	ptrs_t ptrs_r;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	gpr_file dut (.clk(clk), .rst(rst), .ce(ce), .rd_req(rd_req), .wr_req(wr_req),
		.ptr_req(ptr_req), .rd_valid_r(rd_valid_r), .rd_a_data_r(a_d), .rd_b_data_r(b_d),
		.rd_a_abs_r(a_abs), .rd_b_abs_r(b_abs), .wr_busy_r(wr_busy_r), .ptrs_r(ptrs_r));
	pipe_model pipe (.clk(clk), .rd_req(rd_req), .wr_req(wr_req), .ptr_req(ptr_req));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic dp);
		pipe.rd(a, b, dp);
		chk({31'h0, rd_valid_r}, 32'h1, "no valid");
	endtask : rd
	// ****
	// scenarios
	// ****
	task automatic t_global();
		pipe.wr(8'h40, 32'hdead_0040, 32'h0, 1'b0, 1'b1);
		pipe.wr(8'h7f, 32'h1234_007f, 32'h0, 1'b0, 1'b1);
		rd(8'h40, 8'h7f, 1'b0);
		chk(a_d, 32'hdead_0040, "global 40");
		chk(b_d, 32'h1234_007f, "global 7f");
		chk({24'h0, b_abs}, 32'h7f, "global abs");
		rd(8'h02, 8'h3f, 1'b0);
		chk(a_d | b_d, 32'h0, "unstored");
		$display("test global done");
	endtask : t_global
	// base 3 from sp bits 8:2; the first read after the write still sees base 0
	task automatic t_local();
		pipe.wr(8'h01, 32'h0000_020c, 32'h0, 1'b0, 1'b1);
		rd(8'h85, 8'h85, 1'b0);
		chk({24'h0, a_abs}, 32'h85, "base too early");
		rd(8'h85, 8'hff, 1'b0);
		chk({a_abs, b_abs}, 32'h8882, "local abs");
		pipe.wr(8'h85, 32'hcafe_0088, 32'h0, 1'b0, 1'b1);
		pipe.wr(8'h01, 32'h0000_0040, 32'h0, 1'b0, 1'b0);
		rd(8'h01, 8'h85, 1'b0);
		chk(a_d, 32'h0000_0040, "sp word");
		chk(b_d, 32'hcafe_0088, "local data");
		chk({24'h0, b_abs}, 32'h88, "shadow moved");
		// by now a wrongly moved shadow would have reached the translator
		rd(8'h85, 8'h01, 1'b0);
		chk({24'h0, a_abs}, 32'h88, "shadow moved late");
		$display("test local done");
	endtask : t_local
	task automatic t_indirect();
		pipe.mtsr(SEL_OPERAND_A, 32'h0000_0220);
		pipe.mtsr(SEL_OPERAND_B, 32'h0000_0214);
		pipe.mtsr(SEL_RESULT, 32'h0000_0100);
		#1;
		chk({8'h0, ptrs_r}, 32'h0088_8540, "pointers");
		pipe.wr(8'h00, 32'h5a5a_0040, 32'h0, 1'b0, 1'b1);
		rd(8'h00, 8'h00, 1'b0);
		chk(a_d, 32'hcafe_0088, "ptr a data");
		chk({a_abs, b_abs}, 32'h8885, "ptr abs");
		rd(8'h40, 8'h40, 1'b0);
		chk(a_d, 32'h5a5a_0040, "ptr c write");
		// base is 3: local numbers get the addition, the global 7f stays unchanged
		pipe.setip(8'h81, 8'h7f, 8'h90);
		#1;
		chk({8'h0, ptrs_r}, 32'h0084_7f93, "set all");
		// code 3 names no pointer, so nothing may move
		pipe.mtsr(ptr_sel_t'(2'h3), 32'h0000_03fc);
		#1;
		chk({8'h0, ptrs_r}, 32'h0084_7f93, "no pointer");
		$display("test indirect done");
	endtask : t_indirect
	task automatic t_double();
		pipe.wr(8'h50, 32'h1111_0050, 32'h2222_0051, 1'b1, 1'b1);
		#1;
		chk({31'h0, wr_busy_r}, 32'h1, "dbl busy");
		pipe.wr(8'h60, 32'h3333_0060, 32'h0, 1'b0, 1'b1);
		rd(8'h50, 8'h60, 1'b1);
		chk(a_d, 32'h1111_0050, "dbl low");
		chk(b_d, 32'h2222_0051, "dbl high");
		rd(8'h60, 8'h60, 1'b0);
		chk(a_d, 32'h3333_0060, "after dbl");
		$display("test double done");
	endtask : t_double
	// a write offered while the clock enable is low must not land
	task automatic t_hold();
		pipe.wr(8'h41, 32'h0000_0041, 32'h0, 1'b0, 1'b1);
		ce <= 1'b0;
		pipe.wr(8'h41, 32'hffff_ffff, 32'h0, 1'b0, 1'b1);
		ce <= 1'b1;
		rd(8'h41, 8'h41, 1'b0);
		chk(a_d, 32'h0000_0041, "frozen write landed");
		$display("test hold done");
	endtask : t_hold
	task automatic results();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// hang guard, far above the well under one hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			results();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_global();
		t_local();
		t_indirect();
		t_double();
		t_hold();
		results();
	end
endmodule : windowed_gpr_file_addressing_tb
